// ---- common/trig_sel_pkg.sv ----
// Purpose: shared constants and carriers for the channel trigger selector
// Assumes: 32-bit axi4-lite register access, one clock
// Notes: offsets are byte addresses of aligned words
package trig_sel_pkg;
    localparam logic [3:0] SEL_SOFTWARE = 4'h0;
    localparam logic [3:0] SEL_TIMER_A = 4'h1;
    localparam logic [3:0] SEL_TIMER_B = 4'h2;
    localparam logic [3:0] SEL_PORT0_RX = 4'h3;
    localparam logic [3:0] SEL_PORT0_TX = 4'h4;
    localparam int NUM_SRC = 5;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // control field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_LEVEL_BIT = 5;
    localparam int CTRL_HALT_BIT = 6;
    localparam int CTRL_REQ_BIT = 7;
    localparam int CTRL_VARIANT_BIT = 8;
    // status field positions
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_COUNT_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [8:0] CTRL_RESET = 9'h000;

    typedef struct packed {
        logic timer_a_ch2_compare_flag;
        logic timer_b_ch2_compare_flag;
        logic legacy_port0_rx_flag;
        logic legacy_port0_tx_flag;
        logic universal_port0_rx_flag;
        logic universal_port0_tx_flag;
    } src_flags_t;

    typedef struct packed {
        logic timer_a_ch2_irq_enable;
        logic timer_b_ch2_irq_enable;
        logic legacy_port0_rx_irq_enable;
        logic legacy_port0_tx_irq_enable;
        logic universal_port0_rx_irq_enable;
        logic universal_port0_tx_irq_enable;
    } src_enables_t;

    typedef struct packed {
        logic timer_a_ch2;
        logic timer_b_ch2;
        logic port0_rx;
        logic port0_tx;
    } src_clear_t;
endpackage

// ---- verif/dma_trigger_select_checker.sv ----
// Purpose: checks on trigger outputs
// Assumes: enables steady while a start waits
// Notes: sees top ports only
`timescale 1ns/1ps
`default_nettype none
module dma_trigger_select_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire trig_sel_pkg::src_flags_t src_flags,
    input wire trig_sel_pkg::src_enables_t src_enables,
    input wire trig_sel_pkg::src_clear_t flag_clear,
    input wire logic transfer_start,
    input wire logic cpu_halt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_CLEAR_NEEDS_START:
    assert property ((|flag_clear) |-> transfer_start) else $error("clear without start");
    AST_ONE_CLEAR:
    assert property (transfer_start |-> $onehot0(flag_clear)) else $error("several clears");
    AST_HALT_PAIRS:
    assert property (transfer_start == cpu_halt) else $error("halt not with start");
    AST_START_ONE_CYCLE:
    assert property (transfer_start |=> !transfer_start) else $error("start held");
    AST_TA_MASK:
    assert property (flag_clear.timer_a_ch2 |-> $past(src_flags.timer_a_ch2_compare_flag
        && !src_enables.timer_a_ch2_irq_enable)) else $error("timer a start masked");
    AST_TB_MASK:
    assert property (flag_clear.timer_b_ch2 |-> $past(src_flags.timer_b_ch2_compare_flag
        && !src_enables.timer_b_ch2_irq_enable)) else $error("timer b start masked");
    AST_RX_MASK:
    assert property (flag_clear.port0_rx |-> $past((src_flags.legacy_port0_rx_flag
        && !src_enables.legacy_port0_rx_irq_enable) || (src_flags.universal_port0_rx_flag
        && !src_enables.universal_port0_rx_irq_enable))) else $error("rx start masked");
    AST_TX_MASK:
    assert property (flag_clear.port0_tx |-> $past((src_flags.legacy_port0_tx_flag
        && !src_enables.legacy_port0_tx_irq_enable) || (src_flags.universal_port0_tx_flag
        && !src_enables.universal_port0_tx_irq_enable))) else $error("tx start masked");
    cover property (flag_clear.port0_tx);
    cover property (transfer_start && flag_clear == 4'h0);
    cover property (flag_clear.timer_a_ch2);
endmodule
`default_nettype wire

// ---- verif/src_model.sv ----
// Purpose: flags of timers and serial port 0
// Assumes: bench pulses set and drop requests
// Notes: both port variants cleared, a part has one
`timescale 1ns/1ps
`default_nettype none
module src_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] set_req,
    input wire logic [5:0] drop_req,
    input wire trig_sel_pkg::src_clear_t flag_clear,
    output trig_sel_pkg::src_flags_t flags
);
    logic [5:0] flags_r;
    logic [5:0] clr;
    assign clr = {flag_clear[3:2], flag_clear[1:0], flag_clear[1:0]};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_r <= 6'h00;
        else
            flags_r <= (flags_r & ~clr & ~drop_req) | set_req;
    end
    assign flags = flags_r;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: bench for the trigger selector
// Assumes: axi4-lite master tasks
// Notes: enables change only while no start waits
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic instr_done = 1'h0, start, halt;
    logic [5:0] set_req = 6'h00, drop_req = 6'h00;
    trig_sel_pkg::src_flags_t flags;
    trig_sel_pkg::src_enables_t en = 6'h00;
    trig_sel_pkg::src_clear_t fclr;
    int error_cnt = 0, n_compared = 0, i, j;
    int n_start = 0, n_want = 0;
    trig_sel_pkg::src_clear_t last_clr;
    logic last_halt;
    always #5 aclk = ~aclk;
    // every start is counted, so a stray one fails the next check
    always @(posedge aclk)
    begin
        if (start === 1'h1)
        begin
            n_start <= n_start + 1;
            last_clr <= fclr;
            last_halt <= halt;
        end
    end
    dma_trigger_select dma_trigger_select_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .src_flags(flags), .src_enables(en), .instruction_done(instr_done),
        .flag_clear(fclr), .transfer_start(start), .cpu_halt(halt));
    src_model src_model_i (.aclk(aclk), .aresetn(aresetn), .set_req(set_req),
        .drop_req(drop_req), .flag_clear(fclr), .flags(flags));
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic c, input string m);
        n_compared++;
        if (c !== 1'h1)
        begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 50 && bvalid !== 1'h1; k++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end
        bready <= 1'h0;
        chk(bvalid === 1'h1 && bresp === er, "write answer");
        if (k == 50)
            conclude();
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] er);
        int k;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 50 && rvalid !== 1'h1; k++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'h0;
        end
        rready <= 1'h0;
        chk(rvalid === 1'h1 && rresp === er && (rdata & m) === d, "read answer");
        if (k == 50)
            conclude();
        @(posedge aclk);
    endtask
    // select written while disabled, then enabled
    task cfg(input logic [3:0] c, input logic v, input logic h);
        wr(8'h00, {23'h0, v, 1'h0, h, 2'h0, c}, 2'h0);
        wr(8'h00, {23'h0, v, 1'h0, h, 2'h1, c}, 2'h0);
    endtask
    task pset(input logic [5:0] s);
        set_req <= s;
        @(posedge aclk);
        set_req <= 6'h00;
        drop_req <= 6'h00;
    endtask
    task expect_start(input logic [3:0] e, input logic want);
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        n_want = n_want + int'(want);
        chk(n_start === n_want && (!want || (last_clr === e && last_halt === 1'h1)), "start");
        @(posedge aclk);
    endtask
    task t_regs;
        rd(8'h00, 32'h0, 32'h1FF, 2'h0);
        wr(8'h04, 32'hF, 2'h2);
        rd(8'h08, 32'h0, 32'hFFFFFFFF, 2'h2);
        $display("regs done");
    endtask
    task t_sources;
        for (j = 0; j < 6; j++)
        begin
            cfg(4'((j < 4) ? j + 1 : j - 1), j >= 4, 1'h0);
            en[5 - j] <= 1'h1;
            pset(6'h20 >> j);
            expect_start(4'h0, 1'h0);
            // flag drops before the mask lifts, else lifting it is a rising trigger
            drop_req <= 6'h20 >> j;
            pset(6'h00);
            en[5 - j] <= 1'h0;
            pset(6'h20 >> j);
            expect_start(4'h8 >> ((j < 4) ? j : j - 2), 1'h1);
            chk(flags[5 - j] === 1'h0, "flag kept");
        end
        $display("sources done");
    endtask
    task t_pending;
        pset(6'h20);
        cfg(4'h1, 1'h0, 1'h0);
        expect_start(4'h0, 1'h0);
        drop_req <= 6'h20;
        pset(6'h00);
        pset(6'h20);
        expect_start(4'h8, 1'h1);
        $display("pending done");
    endtask
    task t_soft;
        cfg(4'h0, 1'h0, 1'h0);
        wr(8'h00, 32'h90, 2'h0);
        expect_start(4'h0, 1'h1);
        rd(8'h00, 32'h10, 32'hFF, 2'h0);
        $display("software done");
    endtask
    task t_halt;
        cfg(4'h2, 1'h0, 1'h1);
        pset(6'h10);
        expect_start(4'h0, 1'h0);
        instr_done <= 1'h1;
        @(posedge aclk);
        instr_done <= 1'h0;
        expect_start(4'h4, 1'h1);
        $display("halt done");
    endtask
    task t_level;
        cfg(4'h2, 1'h0, 1'h0);
        set_req <= 6'h10;
        repeat (4) @(posedge aclk);
        set_req <= 6'h00;
        expect_start(4'h4, 1'h1);
        drop_req <= 6'h10;
        pset(6'h00);
        wr(8'h00, 32'h22, 2'h0);
        wr(8'h00, 32'h32, 2'h0);
        pset(6'h10);
        expect_start(4'h4, 1'h1);
        $display("level done");
    endtask
    task t_codes;
        for (i = 5; i < 16; i++)
        begin
            cfg(i[3:0], 1'h0, 1'h0);
            pset(6'h3F);
            expect_start(4'h0, 1'h0);
            drop_req <= 6'h3F;
            pset(6'h00);
        end
        rd(8'h04, {n_want[15:0], 16'h0000}, 32'hFFFF0000, 2'h0);
        $display("codes done");
    endtask
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs();
        t_sources();
        t_pending();
        t_soft();
        t_halt();
        t_level();
        t_codes();
        conclude();
    end
endmodule
bind dma_trigger_select dma_trigger_select_checker dma_trigger_select_checker_i (
    .aclk(aclk), .aresetn(aresetn), .src_flags(src_flags), .src_enables(src_enables),
    .flag_clear(flag_clear), .transfer_start(transfer_start), .cpu_halt(cpu_halt));
`default_nettype wire

// ---- verilog/dma_trigger_select.sv ----
// Purpose: trigger source selection for one transfer channel
// Assumes: source flags and enables come from logic on aclk
// Notes: transfer engine itself lives elsewhere; this block issues starts
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module dma_trigger_select (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire trig_sel_pkg::src_flags_t src_flags,
    input wire trig_sel_pkg::src_enables_t src_enables,
    input wire logic instruction_done,
    output trig_sel_pkg::src_clear_t flag_clear,
    output logic transfer_start,
    output logic cpu_halt
);
    logic [3:0] trigger_select_field_r;
    logic channel_enable_bit_r;
    logic level_sensitive_bit_r;
    logic halt_after_instruction_bit_r;
    logic software_request_bit_r;
    logic variant_universal_r;
    logic [15:0] start_count_r;
    logic trig_prev_r;
    logic armed_r;
    logic halt_wait_r;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic trig_raw;
    logic fire;
    logic sw_sel;
    logic wr_go;
    logic ctrl_wr;
    logic req_set;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // pick the selected source, masked by its own interrupt enable
    always_comb
    begin
        trig_raw = 1'b0;
        unique case (trigger_select_field_r)
            trig_sel_pkg::SEL_SOFTWARE: trig_raw = software_request_bit_r;
            trig_sel_pkg::SEL_TIMER_A:
                trig_raw = src_flags.timer_a_ch2_compare_flag
                    & ~src_enables.timer_a_ch2_irq_enable;
            trig_sel_pkg::SEL_TIMER_B:
                trig_raw = src_flags.timer_b_ch2_compare_flag
                    & ~src_enables.timer_b_ch2_irq_enable;
            trig_sel_pkg::SEL_PORT0_RX:
                trig_raw = variant_universal_r
                    ? (src_flags.universal_port0_rx_flag
                       & ~src_enables.universal_port0_rx_irq_enable)
                    : (src_flags.legacy_port0_rx_flag
                       & ~src_enables.legacy_port0_rx_irq_enable);
            trig_sel_pkg::SEL_PORT0_TX:
                trig_raw = variant_universal_r
                    ? (src_flags.universal_port0_tx_flag
                       & ~src_enables.universal_port0_tx_irq_enable)
                    : (src_flags.legacy_port0_tx_flag
                       & ~src_enables.legacy_port0_tx_irq_enable);
            default: trig_raw = 1'b0;
        endcase
    end

    // the request bit is the event itself and self-clears at the start
    assign sw_sel = (trigger_select_field_r == trig_sel_pkg::SEL_SOFTWARE);

    // edge mode needs low-to-high; level mode fires while high
    // armed only after the source was seen low while selected
    // the cycle that carries a start is skipped: our clear of the flag lands one edge late
    assign fire = channel_enable_bit_r & trig_raw & ~halt_wait_r & ~transfer_start
        & (sw_sel | (armed_r & (level_sensitive_bit_r | ~trig_prev_r)));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_prev_r <= 1'b1;
            armed_r <= 1'b0;
        end
        else
        begin
            trig_prev_r <= trig_raw;
            // reselecting or disabling forgets the old level
            if (ctrl_wr || !channel_enable_bit_r)
                armed_r <= 1'b0;
            else if (!trig_raw)
                armed_r <= 1'b1;
        end
    end

    // halt now or after the running instruction ends
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            transfer_start <= 1'b0;
            cpu_halt <= 1'b0;
            halt_wait_r <= 1'b0;
            start_count_r <= 16'h0000;
        end
        else
        begin
            transfer_start <= 1'b0;
            cpu_halt <= 1'b0;
            if (fire && !halt_after_instruction_bit_r)
            begin
                transfer_start <= 1'b1;
                cpu_halt <= 1'b1;
                start_count_r <= start_count_r + 16'h0001;
            end
            else if (fire)
                halt_wait_r <= 1'b1;
            else if (halt_wait_r && instruction_done)
            begin
                halt_wait_r <= 1'b0;
                transfer_start <= 1'b1;
                cpu_halt <= 1'b1;
                start_count_r <= start_count_r + 16'h0001;
            end
        end
    end

    // clear the source flag with the start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_clear <= '0;
        else
        begin
            flag_clear <= '0;
            if ((fire && !halt_after_instruction_bit_r) || (halt_wait_r && instruction_done))
            begin
                unique case (trigger_select_field_r)
                    trig_sel_pkg::SEL_TIMER_A: flag_clear.timer_a_ch2 <= 1'b1;
                    trig_sel_pkg::SEL_TIMER_B: flag_clear.timer_b_ch2 <= 1'b1;
                    trig_sel_pkg::SEL_PORT0_RX: flag_clear.port0_rx <= 1'b1;
                    trig_sel_pkg::SEL_PORT0_TX: flag_clear.port0_tx <= 1'b1;
                    default: flag_clear <= '0;
                endcase
            end
        end
    end

    // write channel: address and data taken in either order
    assign wr_go = (aw_held_r | s_axi_awvalid) & (w_held_r | s_axi_wvalid) & ~s_axi_bvalid;
    assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
    assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    assign ctrl_wr = wr_go & (wr_addr == trig_sel_pkg::CTRL_OFFSET);
    assign req_set = ctrl_wr & wr_strb[0] & wr_data[trig_sel_pkg::CTRL_REQ_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= trig_sel_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_held_r && !s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !w_held_r && !s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            if (aw_held_r && w_held_r && !s_axi_bvalid)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r == trig_sel_pkg::CTRL_OFFSET)
                    ? trig_sel_pkg::RESP_OKAY : trig_sel_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control register; the request bit is cleared as its transfer starts
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {variant_universal_r, software_request_bit_r, halt_after_instruction_bit_r,
             level_sensitive_bit_r, channel_enable_bit_r, trigger_select_field_r}
                <= trig_sel_pkg::CTRL_RESET;
        end
        else
        begin
            if (aw_held_r && w_held_r && !s_axi_bvalid
                && aw_addr_r == trig_sel_pkg::CTRL_OFFSET)
            begin
                if (w_strb_r[0])
                begin
                    trigger_select_field_r <= w_data_r[trig_sel_pkg::CTRL_SEL_LSB +: 4];
                    channel_enable_bit_r <= w_data_r[trig_sel_pkg::CTRL_EN_BIT];
                    level_sensitive_bit_r <= w_data_r[trig_sel_pkg::CTRL_LEVEL_BIT];
                    halt_after_instruction_bit_r <= w_data_r[trig_sel_pkg::CTRL_HALT_BIT];
                end
                if (w_strb_r[1])
                    variant_universal_r <= w_data_r[trig_sel_pkg::CTRL_VARIANT_BIT];
            end
            // a new request wins over the clear in the same cycle
            if (req_set && aw_held_r && w_held_r)
                software_request_bit_r <= 1'b1;
            else if (trigger_select_field_r == trig_sel_pkg::SEL_SOFTWARE
                     && ((fire && !halt_after_instruction_bit_r)
                         || (halt_wait_r && instruction_done)))
                software_request_bit_r <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= trig_sel_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            // rvalid waits for the address handshake, as the protocol demands
            if (s_axi_arvalid && s_axi_arready)
                s_axi_rvalid <= 1'b1;
            else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rresp <= trig_sel_pkg::RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr == trig_sel_pkg::CTRL_OFFSET)
                    s_axi_rdata <= {23'h000000, variant_universal_r, software_request_bit_r,
                        halt_after_instruction_bit_r, level_sensitive_bit_r,
                        channel_enable_bit_r, trigger_select_field_r};
                else if (s_axi_araddr == trig_sel_pkg::STATUS_OFFSET)
                    s_axi_rdata <= {start_count_r, 13'h0000, halt_wait_r, trig_raw, armed_r};
                else
                    s_axi_rresp <= trig_sel_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

`default_nettype wire
